//--- include/regulator_i2c_pkg.sv
package regulator_i2c_pkg;

  // ----------------------------------------------------------------
  // bus addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h60;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [4:0] REG_ADDR_TOP = 5'h00;
  localparam int BYTE_BITS = 8;

  // ----------------------------------------------------------------
  // register indices and fields
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_SET0 = 3'h0;
  localparam logic [2:0] IDX_SET1 = 3'h1;
  localparam logic [2:0] IDX_CTRL = 3'h2;
  localparam logic [2:0] IDX_AUX = 3'h3;
  localparam logic [2:0] IDX_STATUS = 3'h5;
  localparam int STAT_WARN_BIT = 0;
  localparam int STAT_SHDN_BIT = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SET0 = 8'h46;
  localparam logic [7:0] RST_SET1 = 8'h42;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_AUX = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ADDR  = 5'b00010,
    ST_REG   = 5'b00100,
    ST_WDATA = 5'b01000,
    ST_RDATA = 5'b10000
  } link_state_t;

endpackage

//--- hdl/regulator_i2c_slave_status.sv
`timescale 1ns/1ps
module regulator_i2c_slave_status
  import regulator_i2c_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic temp_above_120_i,
  input wire logic temp_above_130_i,
  input wire logic temp_above_150_i,
  input wire logic analog_supply_low_i,
  input wire logic logic_supply_low_i,
  output logic power_stage_off_o,
  output logic hs_mode_o,
  output logic thermal_warning_flag_o,
  output logic thermal_shutdown_flag_o,
  output logic [7:0] set0_o,
  output logic [7:0] set1_o,
  output logic [7:0] ctrl_o,
  output logic [7:0] aux_o
);

  // ----------------------------------------------------------------
  // link clock domain: capture SDA at every SCL rising edge
  // ----------------------------------------------------------------
  // the captured bit stays stable until the next rising edge, which is
  // far later than the two-flop delay of the SCL level seen below
  logic scl_cap_reg;

  always_ff @(posedge scl_i) begin
    scl_cap_reg <= sda_i;
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // every pin but nrst_i crosses two flops before any decode, except the data bits taken in scl_cap_reg;
  // the third stage on scl and sda gives the previous level for edge detection
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [2:0] tsync1_reg;
  logic [2:0] tsync2_reg;

  always_ff @(posedge ref_clk_i) begin
    sync1_reg <= {logic_supply_low_i, analog_supply_low_i, sda_i, scl_i};
    sync2_reg <= sync1_reg;
  end

  // thermal comparators have their own pair of flops
  always_ff @(posedge ref_clk_i) begin
    tsync1_reg <= {temp_above_150_i, temp_above_130_i, temp_above_120_i};
    tsync2_reg <= tsync1_reg;
  end

  logic scl_s;
  logic sda_s;
  logic analog_low_s;
  logic logic_low_s;
  logic scl_d_reg;
  logic sda_d_reg;

  assign scl_s = sync2_reg[0];
  assign sda_s = sync2_reg[1];
  assign analog_low_s = sync2_reg[2];
  assign logic_low_s = sync2_reg[3];

  always_ff @(posedge ref_clk_i) begin
    scl_d_reg <= scl_s;
    sda_d_reg <= sda_s;
  end

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  // start and stop need scl high on both samples, so a data change
  // near a clock edge is never taken for a bus condition
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic regs_rst;

  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  // lockout on either supply clears everything (regulator enable plays no part)
  assign regs_rst = ~nrst_i | analog_low_s | logic_low_s;

  // ----------------------------------------------------------------
  // register map helpers
  // ----------------------------------------------------------------
  function automatic logic reg_implemented(input logic [7:0] idx);
    reg_implemented = (idx[7:3] == REG_ADDR_TOP) &&
      (idx[2:0] == IDX_SET0 || idx[2:0] == IDX_SET1 || idx[2:0] == IDX_CTRL ||
       idx[2:0] == IDX_AUX || idx[2:0] == IDX_STATUS);
  endfunction

  // ----------------------------------------------------------------
  // protocol state
  // ----------------------------------------------------------------
  link_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic in_ack_reg;
  logic ack_drive_reg;
  logic tx_drive_reg;
  logic wr_pending_reg;
  logic hs_mode_reg;
  logic [7:0] rd_byte;

  logic [7:0] set0_reg;
  logic [7:0] set1_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] aux_reg;
  logic warn_reg;
  logic shdn_state_reg;
  logic shdn_flag_reg;

  // read data follows the pointer as it stands at the acknowledge end
  always_comb begin
    rd_byte = READ_ZERO;
    if (reg_implemented(ptr_reg)) begin
      unique case (ptr_reg[2:0])
        IDX_SET0: rd_byte = set0_reg;
        IDX_SET1: rd_byte = set1_reg;
        IDX_CTRL: rd_byte = ctrl_reg;
        IDX_AUX: rd_byte = aux_reg;
        IDX_STATUS: begin
          rd_byte[STAT_WARN_BIT] = warn_reg;
          rd_byte[STAT_SHDN_BIT] = shdn_flag_reg;
        end
        default: rd_byte = READ_ZERO;
      endcase
    end
  end

  // bit counter and receive shifter: bits taken on SCL rising edges
  always_ff @(posedge ref_clk_i) begin
    if (regs_rst || start_det || stop_det) begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
    end else if (scl_rise && state_reg != ST_IDLE) begin
      // the ninth rise is the acknowledge and is not shifted in
      if (bit_cnt_reg == 4'(BYTE_BITS)) begin
        bit_cnt_reg <= 4'h0;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        shift_reg <= {shift_reg[6:0], scl_cap_reg};
      end
    end
  end

  // state machine: decisions at SCL falling edges, except a read nack taken at the ninth rise
  // the pull-down only moves after a fall has been seen, so the line is
  // settled well before the master's next rising edge; a start or stop
  // always drops any drive and any half-written byte
  always_ff @(posedge ref_clk_i) begin
    if (regs_rst) begin
      state_reg <= ST_IDLE;
      in_ack_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
      tx_drive_reg <= 1'b0;
      wr_pending_reg <= 1'b0;
      ptr_reg <= 8'h00;
      tx_reg <= 8'h00;
    end else if (start_det) begin
      state_reg <= ST_ADDR;
      in_ack_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
      tx_drive_reg <= 1'b0;
      wr_pending_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      in_ack_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
      tx_drive_reg <= 1'b0;
      wr_pending_reg <= 1'b0;
    end else if (scl_rise && state_reg == ST_RDATA && bit_cnt_reg == 4'(BYTE_BITS)) begin
      // master refused the byte: release and wait for stop or restart
      if (scl_cap_reg) begin
        state_reg <= ST_IDLE;
        in_ack_reg <= 1'b0;
      end
    end else if (scl_fall) begin
      // nothing happens in idle until the next start
      if (bit_cnt_reg == 4'(BYTE_BITS) && state_reg != ST_IDLE) begin
        // a full byte is in; open the acknowledge slot
        in_ack_reg <= 1'b1;
        tx_drive_reg <= 1'b0;
        unique case (state_reg)
          ST_ADDR: begin
            if (shift_reg[7:1] == SLAVE_ADDR) begin
              ack_drive_reg <= 1'b1;
            end else begin
              state_reg <= ST_IDLE;
              in_ack_reg <= 1'b0;
            end
          end
          ST_REG: begin
            ack_drive_reg <= 1'b1;
            ptr_reg <= shift_reg;
          end
          ST_WDATA: begin
            ack_drive_reg <= 1'b1;
            wr_pending_reg <= 1'b1;
          end
          ST_RDATA: ack_drive_reg <= 1'b0;
          default: ack_drive_reg <= 1'b0;
        endcase
      end else if (bit_cnt_reg == 4'h0 && in_ack_reg) begin
        // acknowledge slot ends here
        in_ack_reg <= 1'b0;
        ack_drive_reg <= 1'b0;
        wr_pending_reg <= 1'b0;
        unique case (state_reg)
          ST_ADDR: begin
            if (shift_reg[0]) begin
              state_reg <= ST_RDATA;
              tx_reg <= rd_byte;
              tx_drive_reg <= ~rd_byte[7];
              ptr_reg <= ptr_reg + 8'h01;
            end else begin
              state_reg <= ST_REG;
            end
          end
          ST_REG: state_reg <= ST_WDATA;
          ST_WDATA: ptr_reg <= ptr_reg + 8'h01;
          ST_RDATA: begin
            tx_reg <= rd_byte;
            tx_drive_reg <= ~rd_byte[7];
            ptr_reg <= ptr_reg + 8'h01;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end else if (state_reg == ST_RDATA && bit_cnt_reg != 4'h0) begin
        // next read bit goes out after each fall, msb first
        tx_drive_reg <= ~tx_reg[3'(7 - bit_cnt_reg)];
      end
    end
  end

  // high-speed mode: armed by master code, dropped by stop
  // the code byte itself is never acknowledged
  always_ff @(posedge ref_clk_i) begin
    if (regs_rst || stop_det) begin
      hs_mode_reg <= 1'b0;
    end else if (scl_fall && state_reg == ST_ADDR && bit_cnt_reg == 4'(BYTE_BITS) &&
                 shift_reg[7:3] == HS_CODE_TOP) begin
      hs_mode_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // writes land at the fall that ends the data acknowledge, so a stop
  // right after the acknowledge cannot lose the byte
  logic commit;
  logic stat_write;

  assign commit = scl_fall && in_ack_reg && bit_cnt_reg == 4'h0 && wr_pending_reg &&
                  state_reg == ST_WDATA && reg_implemented(ptr_reg);
  assign stat_write = commit && ptr_reg[2:0] == IDX_STATUS;

  always_ff @(posedge ref_clk_i) begin
    if (regs_rst) begin
      set0_reg <= RST_SET0;
      set1_reg <= RST_SET1;
      ctrl_reg <= RST_CTRL;
      aux_reg <= RST_AUX;
    end else if (commit) begin
      unique case (ptr_reg[2:0])
        IDX_SET0: set0_reg <= shift_reg;
        IDX_SET1: set1_reg <= shift_reg;
        IDX_CTRL: ctrl_reg <= shift_reg;
        IDX_AUX: aux_reg <= shift_reg;
        default: aux_reg <= aux_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // thermal monitoring
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (regs_rst) begin
      warn_reg <= 1'b0;
    end else begin
      warn_reg <= tsync2_reg[0];
    end
  end

  // hysteresis: set by the upper comparator, kept until the middle one
  // drops, so the power stage does not chatter
  always_ff @(posedge ref_clk_i) begin
    if (regs_rst) begin
      shdn_state_reg <= 1'b0;
    end else if (tsync2_reg[2]) begin
      shdn_state_reg <= 1'b1;
    end else if (!tsync2_reg[1]) begin
      shdn_state_reg <= 1'b0;
    end
  end

  // a new shutdown event wins over a host clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (regs_rst) begin
      shdn_flag_reg <= 1'b0;
    end else if (tsync2_reg[2]) begin
      shdn_flag_reg <= 1'b1;
    end else if (stat_write && !shift_reg[STAT_SHDN_BIT]) begin
      shdn_flag_reg <= 1'b0;
    end
  end

  // held off through reset so the stage never switches on with
  // registers that have not yet reached their defaults
  logic pstage_off_reg;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pstage_off_reg <= 1'b1;
    end else begin
      pstage_off_reg <= shdn_state_reg | analog_low_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open drain: the data level is tied low and only the enable moves
  assign sda_o = 1'b0;
  assign sda_oe_o = ack_drive_reg | tx_drive_reg;
  assign power_stage_off_o = pstage_off_reg;
  assign hs_mode_o = hs_mode_reg;
  assign thermal_warning_flag_o = warn_reg;
  assign thermal_shutdown_flag_o = shdn_flag_reg;
  assign set0_o = set0_reg;
  assign set1_o = set1_reg;
  assign ctrl_o = ctrl_reg;
  assign aux_o = aux_reg;

endmodule

//--- testbench/regulator_i2c_checker.sv
`timescale 1ns/1ps
module regulator_i2c_checker
  import regulator_i2c_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic temp_above_120_i,
  input wire logic temp_above_130_i,
  input wire logic temp_above_150_i,
  input wire logic analog_supply_low_i,
  input wire logic logic_supply_low_i,
  input wire logic power_stage_off_o,
  input wire logic hs_mode_o,
  input wire logic thermal_warning_flag_o,
  input wire logic thermal_shutdown_flag_o,
  input wire logic [7:0] set0_o,
  input wire logic [7:0] set1_o,
  input wire logic [7:0] ctrl_o,
  input wire logic [7:0] aux_o
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  a_logic_lockout: assert property (
    logic_supply_low_i [*5] |-> set0_o == RST_SET0 && aux_o == RST_AUX)
    else $error("logic lockout kept registers");
  a_analog_lockout: assert property (
    analog_supply_low_i [*5] |-> power_stage_off_o && set1_o == RST_SET1 && ctrl_o == RST_CTRL)
    else $error("analog lockout not applied");
  a_warn_set: assert property (
    temp_above_120_i [*6] |-> thermal_warning_flag_o)
    else $error("warning flag missing");
  a_shdn_enter: assert property (
    temp_above_150_i [*6] |-> thermal_shutdown_flag_o && power_stage_off_o)
    else $error("shutdown not entered");
  a_shdn_leave: assert property (
    (!temp_above_130_i && !temp_above_150_i && !analog_supply_low_i) [*6] |-> !power_stage_off_o)
    else $error("power stage still off");
  a_flag_latched: assert property (
    (scl_i && thermal_shutdown_flag_o && !logic_supply_low_i && !analog_supply_low_i) [*4]
    |=> thermal_shutdown_flag_o)
    else $error("shutdown flag lost");
  a_drive_scl_low: assert property (
    $changed(sda_oe_o) |-> !scl_i)
    else $error("data line changed with clock high");
  a_stop_release: assert property (
    scl_i && $rose(sda_i) |=> !sda_oe_o [*4])
    else $error("data line held after stop");
  a_hs_stop: assert property (
    hs_mode_o && scl_i && $rose(sda_i) |-> ##[1:6] !hs_mode_o)
    else $error("high speed kept after stop");

  c_hs: cover property ($rose(hs_mode_o));
  c_ack: cover property ($rose(sda_oe_o));
  c_shdn: cover property ($rose(thermal_shutdown_flag_o));
endmodule

bind regulator_i2c_slave_status regulator_i2c_checker i_regulator_i2c_checker (.*);

//--- testbench/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o,
  output logic res_valid_o,
  output logic [8:0] res_o
);
  // ------------------------------------------------------------
  // bus master: clock runs only inside frames, 64 ns period
  // ------------------------------------------------------------
  localparam int HALF = 32;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    res_valid_o = 1'b0;
    res_o = 9'h000;
  end
  task automatic clk_bit(input logic b, output logic s);
    #16 sda_low_o = ~b;
    #16 scl_o = 1'b1;
    #HALF s = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic start;
    #16 sda_low_o = 1'b0;
    #16 scl_o = 1'b1;
    #HALF sda_low_o = 1'b1;
    #HALF scl_o = 1'b0;
  endtask
  task automatic stop;
    #16 sda_low_o = 1'b1;
    #16 scl_o = 1'b1;
    #HALF sda_low_o = 1'b0;
    #HALF;
  endtask
  // wr high sends b and samples the ack, low reads a byte and answers nack if nack is set, else ack
  task automatic xfer(input logic wr, input logic [7:0] b, input logic nack);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(wr ? b[i] : 1'b1, d[i]);
    end
    clk_bit(wr | nack, s);
    res_o = wr ? {1'b1, 7'h00, ~s} : {1'b0, d};
    #1 res_valid_o = 1'b1;
    #1 res_valid_o = 1'b0;
  endtask
endmodule

//--- testbench/regulator_i2c_slave_status_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h expected %h", $time, a, b); end end
module regulator_i2c_slave_status_tb;
  import regulator_i2c_pkg::*;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic t120 = 1'b0, t130 = 1'b0, t150 = 1'b0, alow = 1'b0, llow = 1'b0;
  wire scl, sda, sda_low_m, res_valid, sda_o, sda_oe_o, hs, warn, shdn, pwr_off;
  wire [8:0] res;
  wire [7:0] set0_o, set1_o, ctrl_o, aux_o;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [8:0] exp_q[$];
  logic [8:0] exp_v;
  logic [7:0] mem[4] = '{RST_SET0, RST_SET1, RST_CTRL, RST_AUX};
  logic [7:0] bad[4] = '{8'hC2, 8'h00, 8'hF0, 8'h40};

  assign sda = sda_low_m ? 1'b0 : (sda_oe_o === 1'b1) ? sda_o : 1'b1;
  regulator_i2c_slave_status i_regulator_i2c_slave_status (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .temp_above_120_i(t120), .temp_above_130_i(t130), .temp_above_150_i(t150),
    .analog_supply_low_i(alow), .logic_supply_low_i(llow), .power_stage_off_o(pwr_off),
    .hs_mode_o(hs), .thermal_warning_flag_o(warn), .thermal_shutdown_flag_o(shdn),
    .set0_o(set0_o), .set1_o(set1_o), .ctrl_o(ctrl_o), .aux_o(aux_o));
  i2c_host_model i_i2c_host_model (.sda_i(sda), .scl_o(scl), .sda_low_o(sda_low_m),
    .res_valid_o(res_valid), .res_o(res));

  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      test_done();
    end
  end
  // ------------------------------------------------------------
  // result monitor and bus helpers
  // ------------------------------------------------------------
  always @(posedge res_valid) begin
    if (exp_q.size() == 0) begin
      error_cnt++;
      $display("[ERR] %0t unexpected result", $time);
    end else begin
      exp_v = exp_q.pop_front();
      `CHK(res, exp_v)
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] b, input logic ack);
    exp_q.push_back({1'b1, 7'h00, ack});
    i_i2c_host_model.xfer(1'b1, b, 1'b0);
  endtask
  task automatic put(input logic [2:0] idx, input logic [7:0] d);
    i_i2c_host_model.start();
    wr({SLAVE_ADDR, 1'b0}, 1'b1);
    wr({REG_ADDR_TOP, idx}, 1'b1);
    wr(d, 1'b1);
    i_i2c_host_model.stop();
  endtask
  task automatic get(input logic [2:0] idx, input logic [7:0] e);
    i_i2c_host_model.start();
    wr({SLAVE_ADDR, 1'b0}, 1'b1);
    wr({REG_ADDR_TOP, idx}, 1'b1);
    i_i2c_host_model.start();
    wr({SLAVE_ADDR, 1'b1}, 1'b1);
    exp_q.push_back({1'b0, e});
    i_i2c_host_model.xfer(1'b0, 8'h00, 1'b1);
    i_i2c_host_model.stop();
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hfab9));
    tick(20);
    nrst_i = 1'b1;
    tick(8);
    `CHK({set0_o, set1_o, ctrl_o, aux_o}, {RST_SET0, RST_SET1, RST_CTRL, RST_AUX})
    `CHK({hs, warn, shdn, pwr_off}, 4'b0000)
    for (int i = 0; i < 4; i++) begin
      mem[i] = 8'($urandom());
      put(3'(i), mem[i]);
      tick(4);
      `CHK({set0_o, set1_o, ctrl_o, aux_o}, {mem[0], mem[1], mem[2], mem[3]})
    end
    for (int i = 0; i < 8; i++) get(3'(i), i < 4 ? mem[i] : READ_ZERO);
    foreach (bad[i]) begin
      i_i2c_host_model.start();
      wr(bad[i], 1'b0);
      i_i2c_host_model.stop();
    end
    i_i2c_host_model.start();
    wr(8'h0B, 1'b0);
    tick(6);
    `CHK(hs, 1'b1)
    mem[1] = 8'($urandom());
    put(IDX_SET1, mem[1]);
    tick(4);
    `CHK({hs, set1_o}, {1'b0, mem[1]})
    t120 = 1'b1;
    tick(8);
    `CHK(warn, 1'b1)
    t130 = 1'b1;
    t150 = 1'b1;
    tick(8);
    `CHK({shdn, pwr_off}, 2'b11)
    get(IDX_STATUS, 8'h03);
    get(IDX_SET1, mem[1]);
    t150 = 1'b0;
    tick(8);
    `CHK(pwr_off, 1'b1)
    t130 = 1'b0;
    t120 = 1'b0;
    tick(8);
    `CHK({shdn, pwr_off, warn}, 3'b100)
    put(IDX_STATUS, 8'h00);
    tick(4);
    `CHK(shdn, 1'b0)
    llow = 1'b1;
    tick(8);
    `CHK({set0_o, set1_o, ctrl_o, aux_o}, {RST_SET0, RST_SET1, RST_CTRL, RST_AUX})
    llow = 1'b0;
    tick(8);
    put(IDX_CTRL, 8'h5A);
    tick(4);
    `CHK(ctrl_o, 8'h5A)
    alow = 1'b1;
    tick(8);
    `CHK({pwr_off, ctrl_o}, {1'b1, RST_CTRL})
    alow = 1'b0;
    tick(8);
    `CHK({pwr_off, ctrl_o}, {1'b0, RST_CTRL})
    `CHK(exp_q.size(), 0)
    test_done();
  end
endmodule
